// ### design/led_defines.svh
// timing and encoding constants for the status indicator driver
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH
// system clock rate in kHz
`define CLK_KHZ            40000
// base tick period in microseconds
`define TICK_US            25000
// clock cycles per tick
`define TICK_CYCLES        ((`TICK_US * `CLK_KHZ) / 1000)
// flicker tick period in microseconds
`define FLICK_US           5000
`define FLICK_CYCLES       ((`FLICK_US * `CLK_KHZ) / 1000)
// ticks per flashing half period
`define BLINK_TICKS        8
// single flash: on ticks, then whole period in ticks
`define SFLASH_ON_TICKS    8
`define SFLASH_PERIOD      48
// activity stretch length in ticks
`define ACT_STRETCH_TICKS  4
// state codes reported by the slave state machine
`define ST_INIT            4'h1
`define ST_PREOP           4'h2
`define ST_BOOT            4'h3
`define ST_SAFEOP          4'h4
`define ST_OP              4'h8
`endif

// ### design/led_pkg.sv
// types for the status indicator driver
package led_pkg;
    // run indicator display modes
    typedef enum logic [4:0] {
        MODE_OFF    = 5'h01,
        MODE_BLINK  = 5'h02,
        MODE_SINGLE = 5'h04,
        MODE_ON     = 5'h08,
        MODE_FLICK  = 5'h10
    } run_mode_t;
endpackage : led_pkg

// ### design/coupler_status_led_driver.sv
// status indicator driver: run LED plus three link/activity LEDs
//
// Summary of operation
// [R1] init state keeps run LED dark
// [R2] pre-operational blinks run LED evenly
// [R3] safe-operational gives short flash, long dark
// [R4] operational holds run LED lit
// [R5] bootstrap flickers run LED faster
// [R6] incoming LED dark without link
// [R7] incoming LED steady when linked, idle
// [R8] incoming LED flashes during traffic
// [R9] outgoing LED dark without link
// [R10] outgoing LED steady when linked, idle
// [R11] outgoing LED flashes during traffic
// [R12] terminal bus LED dark without connection
// [R13] terminal bus steady idle, flashing busy
// [R14] blink timing from clock divider constants
// [R15] activity stretched, overrides steady linked
`timescale 1ns/1ps
`default_nettype none
`include "led_defines.svh"
module coupler_status_led_driver
    import led_pkg::*;
#(
    parameter int TICK_CYCLES  = `TICK_CYCLES,
    parameter int FLICK_CYCLES = `FLICK_CYCLES
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // slave state machine state (same clock domain)
    input  wire logic [3:0] esm_state,
    // per port link and activity flags (pins, synchronised here)
    input  wire logic [2:0] link_up,
    input  wire logic [2:0] activity,
    // indicator levels, high lights the LED
    output var  logic       run_led,
    output var  logic [2:0] link_act_led
);
    // port indices: 0 incoming_port, 1 outgoing_port, 2 terminal bus
    localparam int NP = 3;

    // tick dividers
    logic [31:0] tick_cnt, next_tick_cnt;        // base tick divider
    logic [31:0] flick_cnt, next_flick_cnt;      // flicker divider
    logic        tick, next_tick;                // one-cycle base tick
    logic        flick_ph, next_flick_ph;        // flicker phase
    logic [5:0]  phase, next_phase;              // pattern phase counter

    // divider: one-cycle base tick and toggling flicker phase from the single clock
    always_comb begin
        next_tick_cnt  = tick_cnt + 32'h1;
        next_tick      = 1'b0;
        next_flick_cnt = flick_cnt + 32'h1;
        next_flick_ph  = flick_ph;
        next_phase     = phase;
        if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin // [R14]
            next_tick_cnt = 32'h0;
            next_tick     = 1'b1;
        end
        if (flick_cnt >= 32'(FLICK_CYCLES - 1)) begin
            next_flick_cnt = 32'h0;
            next_flick_ph  = ~flick_ph;
        end
        if (tick) begin
            // phase wraps at the single flash period
            if (phase == 6'(`SFLASH_PERIOD - 1)) begin
                next_phase = 6'h00;
            end else begin
                next_phase = phase + 6'h01;
            end
        end
    end

    // divider registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick_cnt  <= 32'h0;
            flick_cnt <= 32'h0;
            tick      <= 1'b0;
            flick_ph  <= 1'b0;
            phase     <= 6'h00;
        end else begin
            tick_cnt  <= next_tick_cnt;
            flick_cnt <= next_flick_cnt;
            tick      <= next_tick;
            flick_ph  <= next_flick_ph;
            phase     <= next_phase;
        end
    end

    // even blink: high for BLINK_TICKS, low for BLINK_TICKS
    function automatic logic blink_of(input logic [5:0] ph);
        blink_of = ((ph / 6'(`BLINK_TICKS)) % 6'h02) == 6'h00;
    endfunction : blink_of

    // run indicator mode decode
    run_mode_t mode;
    always_comb begin
        case (esm_state)
            `ST_INIT:   mode = MODE_OFF;    // [R1]
            `ST_PREOP:  mode = MODE_BLINK;  // [R2]
            `ST_SAFEOP: mode = MODE_SINGLE; // [R3]
            `ST_OP:     mode = MODE_ON;     // [R4]
            `ST_BOOT:   mode = MODE_FLICK;  // [R5]
            default:    mode = MODE_OFF;
        endcase
    end

    // run LED next level
    logic next_run_led;
    always_comb begin
        case (mode)
            MODE_OFF:    next_run_led = 1'b0;                                  // [R1]
            MODE_BLINK:  next_run_led = blink_of(phase);                       // [R2]
            MODE_SINGLE: next_run_led = phase < 6'(`SFLASH_ON_TICKS);          // [R3]
            MODE_ON:     next_run_led = 1'b1;                                  // [R4]
            MODE_FLICK:  next_run_led = flick_ph;                              // [R5]
            default:     next_run_led = 1'b0;
        endcase
    end

    // pin synchronisers: three stages, change accepted when 2nd and 3rd agree
    logic [NP-1:0] lk_s1, lk_s2, lk_s3, lk_q, next_lk_q;
    logic [NP-1:0] ac_s1, ac_s2, ac_s3, ac_q, next_ac_q;
    always_comb begin
        next_lk_q = lk_q;
        next_ac_q = ac_q;
        for (int i = 0; i < NP; i++) begin
            if (lk_s2[i] == lk_s3[i]) begin
                next_lk_q[i] = lk_s3[i];
            end
            if (ac_s2[i] == ac_s3[i]) begin
                next_ac_q[i] = ac_s3[i];
            end
        end
    end

    // activity stretch per port
    logic [2:0]    stretch [NP];       // remaining stretch ticks
    logic [2:0]    next_stretch [NP];
    logic [NP-1:0] next_la_led;        // link/activity next levels
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            next_stretch[i] = stretch[i];
            // new activity reloads, so a single frame is always shown
            if (ac_q[i] && lk_q[i]) begin
                next_stretch[i] = 3'(`ACT_STRETCH_TICKS); // [R15]
            end else if (tick && stretch[i] != 3'h0) begin
                next_stretch[i] = stretch[i] - 3'h1;
            end
            if (!lk_q[i]) begin
                next_la_led[i] = 1'b0;                 // [R6] [R9] [R12]
            end else if (stretch[i] != 3'h0) begin
                next_la_led[i] = phase[1];             // [R8] [R11] [R13] [R15]
            end else begin
                next_la_led[i] = 1'b1;                 // [R7] [R10] [R13]
            end
        end
    end

    // registers for synchronisers, stretch and outputs
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lk_s1        <= '0;
            lk_s2        <= '0;
            lk_s3        <= '0;
            lk_q         <= '0;
            ac_s1        <= '0;
            ac_s2        <= '0;
            ac_s3        <= '0;
            ac_q         <= '0;
            run_led      <= 1'b0;
            link_act_led <= '0;
            for (int i = 0; i < NP; i++) begin
                stretch[i] <= 3'h0;
            end
        end else begin
            lk_s1        <= link_up;
            lk_s2        <= lk_s1;
            lk_s3        <= lk_s2;
            lk_q         <= next_lk_q;
            ac_s1        <= activity;
            ac_s2        <= ac_s1;
            ac_s3        <= ac_s2;
            ac_q         <= next_ac_q;
            run_led      <= next_run_led;
            link_act_led <= next_la_led;
            for (int i = 0; i < NP; i++) begin
                stretch[i] <= next_stretch[i];
            end
        end
    end

    // assertions
    a_init_dark: assert property (@(posedge ref_clk) disable iff (reset) // [R1]
        esm_state == `ST_INIT |=> !run_led)
        else $error("run led lit in init");
    a_op_lit: assert property (@(posedge ref_clk) disable iff (reset) // [R4]
        esm_state == `ST_OP |=> run_led)
        else $error("run led dark in operational");
    a_preop_blink: assert property (@(posedge ref_clk) disable iff (reset) // [R2]
        esm_state == `ST_PREOP |=> run_led == blink_of($past(phase)))
        else $error("pre-operational blink wrong");
    a_safeop_flash: assert property (@(posedge ref_clk) disable iff (reset) // [R3]
        esm_state == `ST_SAFEOP && phase >= 6'(`SFLASH_ON_TICKS) |=> !run_led)
        else $error("single flash lit during dark interval");
    a_boot_flick: assert property (@(posedge ref_clk) disable iff (reset) // [R5]
        esm_state == `ST_BOOT |=> run_led == $past(flick_ph))
        else $error("bootstrap flicker wrong");
    a_nolink_dark: assert property (@(posedge ref_clk) disable iff (reset) // [R6]
        !lk_q[0] |=> !link_act_led[0])
        else $error("incoming led lit without link");
    a_out_dark: assert property (@(posedge ref_clk) disable iff (reset) // [R9]
        !lk_q[1] |=> !link_act_led[1])
        else $error("outgoing led lit without link");
    a_bus_dark: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
        !lk_q[2] |=> !link_act_led[2])
        else $error("terminal bus led lit without link");
    a_idle_steady: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
        lk_q[0] && stretch[0] == 3'h0 |=> link_act_led[0])
        else $error("linked idle incoming led not lit");
    a_act_stretch: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
        ac_q[0] && lk_q[0] |=> stretch[0] == 3'(`ACT_STRETCH_TICKS))
        else $error("activity not stretched");
endmodule : coupler_status_led_driver
`default_nettype wire

// ### testbench/peer_link.sv
// far side network peers: link presence and frame activity per port
`timescale 1ns/1ps
`default_nettype none
module peer_link (
    // clock
    input  wire logic       ref_clk,
    // requests from the bench
    input  wire logic [2:0] want_link,
    input  wire logic [2:0] send_frame,
    // pins towards the coupler
    output var  logic [2:0] link_up,
    output var  logic [2:0] activity
);
    int hold [3] = '{0, 0, 0};  // cycles left in each frame pulse
    // pins move on the falling edge; a frame shows for four cycles
    always @(negedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            link_up[i] <= want_link[i];
            if (send_frame[i]) hold[i] = 4;
            activity[i] <= (hold[i] != 0);
            if (hold[i] != 0) hold[i] = hold[i] - 1;
        end
    end
endmodule : peer_link
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the status indicator driver
`timescale 1ns/1ps
`default_nettype none
`include "led_defines.svh"
module testbench;
    logic       ref_clk      = 1'b0;  // 40 MHz clock
    logic       reset        = 1'b1;  // async reset
    logic [3:0] esm_state    = 4'h1;  // reported state
    logic [2:0] want_link    = 3'h0;  // peer link requests
    logic [2:0] send_frame   = 3'h0;  // peer frame requests
    logic [2:0] link_up;              // peer link pins
    logic [2:0] activity;             // peer activity pins
    logic       run_led;              // run indicator
    logic [2:0] link_act_led;         // port indicators
    int         fail_count   = 0;     // mismatches
    int         total_checks = 0;     // comparisons
    // clock: 25 ns period
    always #12.5 ref_clk = ~ref_clk;
    // short ticks: 4 cycles per tick, 1 per flicker tick
    coupler_status_led_driver #(.TICK_CYCLES(4), .FLICK_CYCLES(1)) coupler_status_led_driver_i (
        .ref_clk(ref_clk), .reset(reset), .esm_state(esm_state), .link_up(link_up),
        .activity(activity), .run_led(run_led), .link_act_led(link_act_led));
    peer_link peer_link_i (.ref_clk(ref_clk), .want_link(want_link), .send_frame(send_frame),
        .link_up(link_up), .activity(activity));
    // compare counts
    task automatic check_count(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check_count
    // compare indicator levels
    task automatic check_bits(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check_bits
    // compare a condition
    task automatic check_true(input logic c);
        check_bits({3'h0, c}, 4'h1);
    endtask : check_true
    // verdict and end of run
    task automatic summarize;
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // count lit cycles and rising edges of one indicator over n cycles (3 = run)
    task automatic measure(input int sel, input int n, output int highs, output int rises);
        logic prev;
        logic cur;
        highs = 0;
        rises = 0;
        prev  = 1'b0;
        for (int k = 0; k <= n; k++) begin
            @(posedge ref_clk);
            #1 cur = (sel == 3) ? run_led : link_act_led[sel];
            if (k > 0 && cur === 1'b1) highs++;
            // an unknown level spoils the lit count
            if (k > 0 && $isunknown(cur)) highs += 1000;
            if (k > 0 && cur === 1'b1 && prev === 1'b0) rises++;
            prev = cur;
        end
    endtask : measure
    // run indicator pattern for one state; a negative figure means skip or more than
    task automatic run_case(input logic [3:0] st, input int exp_high, input int exp_rise);
        int h;
        int r;
        @(negedge ref_clk) esm_state <= st;
        repeat (4) @(posedge ref_clk);
        measure(3, 384, h, r);
        if (exp_high >= 0) check_count(h, exp_high);
        if (exp_rise >= 0) check_count(r, exp_rise);
        else check_true(r > -exp_rise);
    endtask : run_case
    // one port: dark without link, steady when idle, flashing with traffic, stretch
    task automatic port_case(input int p);
        int h;
        int r;
        // frames without a link must leave the indicator dark
        @(negedge ref_clk) send_frame[p] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        measure(p, 32, h, r);
        check_count(h, 0);
        // let the frame tail die out before the link comes up
        @(negedge ref_clk) send_frame[p] <= 1'b0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) want_link[p] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        measure(p, 64, h, r);
        check_count(h, 64);
        // steady traffic: activity flashing over four flash periods
        @(negedge ref_clk) send_frame[p] <= 1'b1;
        repeat (12) @(posedge ref_clk);
        measure(p, 64, h, r);
        check_count(h, 32);
        check_count(r, 4);
        @(negedge ref_clk) send_frame[p] <= 1'b0;
        repeat (64) @(posedge ref_clk);
        // a single short frame still gives a visible flash
        @(negedge ref_clk) send_frame[p] <= 1'b1;
        @(negedge ref_clk) send_frame[p] <= 1'b0;
        measure(p, 40, h, r);
        check_true(h < 40);
        check_true(r > 0);
        repeat (40) @(posedge ref_clk);
        measure(p, 32, h, r);
        check_count(h, 32);
        @(negedge ref_clk) want_link[p] <= 1'b0;
        repeat (8) @(posedge ref_clk);
        measure(p, 32, h, r);
        check_count(h, 0);
    endtask : port_case
    // watchdog: the tests need about 4000 cycles
    initial begin
        #500000;
        fail_count++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 check_bits({run_led, link_act_led}, 4'h0);
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) reset <= 1'b0;
        run_case(`ST_INIT, 0, 0);
        run_case(`ST_PREOP, 192, 6);
        run_case(`ST_SAFEOP, 64, 2);
        run_case(`ST_OP, 384, 0);
        run_case(`ST_BOOT, -1, -6);
        run_case(4'h5, 0, 0);
        for (int p = 0; p < 3; p++) port_case(p);
        run_case(`ST_OP, 384, 0);
        @(negedge ref_clk) reset <= 1'b1;
        #1 check_bits({run_led, link_act_led}, 4'h0);
        @(negedge ref_clk) reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 check_bits({run_led, link_act_led}, 4'h8);
        summarize();
    end
endmodule : testbench
`default_nettype wire
